// [logic/cui_clock_unit_irq_status.sv]
// Interrupt and status flags of the master clocking unit, with register port.
// Assumes pin inputs are asynchronous; channel summary bits are on ref_clk.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns

// What this block does
// - PLL lock state readable at bit one
// - Lock bit valid always; compat chooses bit seven
// - Lock change sets flag until register read
// - Reading switch status clears both switch flags, not the lock change flag
// - Show-masked option records masked switch events
// - Masked recorded events skip interrupt and summary
// - DCO reference switch sets flag bit four
// - Auto switching off keeps switch flags zero
// - Transmit clock source switch sets bit three
// - Reference scheme drives transmit clock from DCO
// - Source scheme feeds DCO from fixed reference
// - Reference loss reported regardless of auto switching
// - Clock loss register bit four shows loss
module cui_clock_unit_irq_status (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [cui_pkg::ADDR_W-1:0] regAddr,
  input wire logic [cui_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [cui_pkg::DATA_W-1:0] regRdData,
  input wire logic pllLockRaw,
  input wire logic txRefLossRaw,
  input wire logic [7:0] channelSummaryIn,
  output logic irqOut,
  output logic txClkSrcDco,
  output logic dcoRefFixed
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  cui_pkg::cui_top_s st;
  cui_pkg::cui_top_s next_st;
  logic [cui_pkg::SYNC_W-1:0] syncedPins;
  logic pllLockSync;
  logic txRefLossSync;
  logic dcoRefSwapEvt;
  logic txSrcSwapEvt;
  logic rdPll;
  logic rdSwitch;
  logic wrSwitch;
  logic dcoKeep;
  logic txKeep;
  logic [7:0] switchFlags;
  logic [7:0] switchPending;
  logic [7:0] readMux;

  // ---------------------------------------------------------------------
  // Pin synchronisers: PLL lock in bit 0, reference loss in bit 1
  // ---------------------------------------------------------------------
  cui_sync u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .pinIn({txRefLossRaw, pllLockRaw}),
    .levelOut(syncedPins)
  );

  assign pllLockSync = syncedPins[0];
  assign txRefLossSync = syncedPins[1];

  // ---------------------------------------------------------------------
  // Automatic clock switching selector
  // ---------------------------------------------------------------------
  cui_switch u_switch (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .autoSwitchEn(st.autoSwitchEn),
    .srcSwitchScheme(st.srcSwitchScheme),
    .txRefLoss(txRefLossSync),
    .txClkSrcDco(txClkSrcDco),
    .dcoRefFixed(dcoRefFixed),
    .dcoRefSwapEvt(dcoRefSwapEvt),
    .txSrcSwapEvt(txSrcSwapEvt)
  );

  // ---------------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------------
  assign rdPll = regRdStrobe && (regAddr == cui_pkg::OFS_PLL_LOCK_STATUS);
  assign rdSwitch = regRdStrobe && (regAddr == cui_pkg::OFS_CLOCK_SWITCH_IRQ_STATUS);
  assign wrSwitch = regWrStrobe && (regAddr == cui_pkg::OFS_CLOCK_SWITCH_IRQ_STATUS);

  // Switch flags laid out as in the status register; gated by auto enable
  always_comb
  begin
    switchFlags = 8'h00;
    switchFlags[cui_pkg::POS_DCO_REF_SWAP] = st.dcoRefSwap & st.autoSwitchEn;
    switchFlags[cui_pkg::POS_TXCLK_SRC_SWAP] = st.txSrcSwap & st.autoSwitchEn;
    switchPending = switchFlags & ~st.mask;
  end

  // ---------------------------------------------------------------------
  // Read data selection; unmapped offsets read zero
  // ---------------------------------------------------------------------
  always_comb
  begin
    readMux = 8'h00; // Reserved bits stay zero
    unique case (regAddr)
      cui_pkg::OFS_PLL_LOCK_STATUS:
      begin
        readMux[cui_pkg::POS_PLL_LOCK_STATE] = st.pllLockState;
        readMux[cui_pkg::POS_PLL_LOCK_CHANGED] = st.pllChanged;
      end
      cui_pkg::OFS_CLOCK_SWITCH_IRQ_STATUS:
        readMux = switchFlags;
      cui_pkg::OFS_CHANNEL_IRQ_SUMMARY:
      begin
        readMux = channelSummaryIn;
        // Compat set lends bit seven to the lock state
        readMux[cui_pkg::POS_CHANNEL8_SUMMARY] = st.compatSel ? st.pllLockState
          : channelSummaryIn[cui_pkg::POS_CHANNEL8_SUMMARY];
      end
      cui_pkg::OFS_GLOBAL_CONFIG_REG:
      begin
        readMux[cui_pkg::POS_SHOW_MASKED] = st.showMasked;
        readMux[cui_pkg::POS_COMPAT_SEL] = st.compatSel;
      end
      cui_pkg::OFS_CLOCK_MODE_REG_SIX:
      begin
        readMux[cui_pkg::POS_AUTO_SWITCH_EN] = st.autoSwitchEn;
        readMux[cui_pkg::POS_SRC_SWITCH_SCHEME] = st.srcSwitchScheme;
      end
      cui_pkg::OFS_CLOCK_SWITCH_MASK_REG:
        readMux = st.mask;
      cui_pkg::OFS_CLOCK_LOSS_STATUS_REG:
        readMux[cui_pkg::POS_TX_REF_LOSS_STATE] = txRefLossSync;
      cui_pkg::OFS_GLOBAL_IRQ_SUMMARY:
      begin
        readMux[cui_pkg::POS_SUM_PLL] = st.pllChanged;
        readMux[cui_pkg::POS_SUM_CLOCK_SWITCH] = |switchPending;
      end
      default:
        readMux = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    dcoKeep = 1'b0;
    txKeep = 1'b0;

    // Configuration writes; reserved bits are dropped
    if (regWrStrobe)
    begin
      unique case (regAddr)
        cui_pkg::OFS_GLOBAL_CONFIG_REG:
        begin
          next_st.showMasked = regWrData[cui_pkg::POS_SHOW_MASKED];
          next_st.compatSel = regWrData[cui_pkg::POS_COMPAT_SEL];
        end
        cui_pkg::OFS_CLOCK_MODE_REG_SIX:
        begin
          next_st.autoSwitchEn = regWrData[cui_pkg::POS_AUTO_SWITCH_EN];
          next_st.srcSwitchScheme = regWrData[cui_pkg::POS_SRC_SWITCH_SCHEME];
        end
        cui_pkg::OFS_CLOCK_SWITCH_MASK_REG:
          next_st.mask = regWrData & cui_pkg::MASK_WRITABLE;
        default:
          next_st.mask = st.mask;
      endcase
    end

    // Lock state follows the pin; any change raises the sticky flag.
    // The read clears only what it saw, so a change in that cycle survives.
    next_st.pllLockState = pllLockSync;
    if (pllLockSync != st.pllLockState)
      next_st.pllChanged = 1'b1;
    else if (rdPll)
      next_st.pllChanged = 1'b0;

    // Switch flags: held unless read or written one; masked events only
    // recorded when the show-masked option is on
    dcoKeep = st.dcoRefSwap & ~rdSwitch
      & ~(wrSwitch & regWrData[cui_pkg::POS_DCO_REF_SWAP]);
    txKeep = st.txSrcSwap & ~rdSwitch
      & ~(wrSwitch & regWrData[cui_pkg::POS_TXCLK_SRC_SWAP]);
    next_st.dcoRefSwap = dcoKeep | (dcoRefSwapEvt
      & (~st.mask[cui_pkg::POS_DCO_REF_SWAP] | st.showMasked));
    next_st.txSrcSwap = txKeep | (txSrcSwapEvt
      & (~st.mask[cui_pkg::POS_TXCLK_SRC_SWAP] | st.showMasked));
    if (!st.autoSwitchEn)
    begin
      next_st.dcoRefSwap = 1'b0;
      next_st.txSrcSwap = 1'b0;
    end

    // Interrupt from the new state so it tracks the flags exactly
    next_st.irqOut = next_st.pllChanged
      | (next_st.autoSwitchEn & ~next_st.mask[cui_pkg::POS_DCO_REF_SWAP] & next_st.dcoRefSwap)
      | (next_st.autoSwitchEn & ~next_st.mask[cui_pkg::POS_TXCLK_SRC_SWAP] & next_st.txSrcSwap);

    // Read data stand only in the cycle after the strobe
    next_st.rdData = regRdStrobe ? readMux : cui_pkg::RST_RD_DATA;
  end

  // ---------------------------------------------------------------------
  // State register, frozen while the clock enable is low
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.mask <= cui_pkg::RST_MASK;
      st.showMasked <= cui_pkg::RST_SHOW_MASKED;
      st.compatSel <= cui_pkg::RST_COMPAT_SEL;
      st.autoSwitchEn <= cui_pkg::RST_AUTO_SWITCH_EN;
      st.srcSwitchScheme <= cui_pkg::RST_SRC_SWITCH_SCHEME;
    end
    else if (clkEn)
      st <= next_st;
  end

  assign regRdData = st.rdData;
  assign irqOut = st.irqOut;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_rd_pll;
    clkEn && rdPll;
  endsequence

  sequence s_rd_chan;
    clkEn && regRdStrobe && (regAddr == cui_pkg::OFS_CHANNEL_IRQ_SUMMARY);
  endsequence

  sequence s_rd_loss;
    clkEn && regRdStrobe && (regAddr == cui_pkg::OFS_CLOCK_LOSS_STATUS_REG);
  endsequence

  sequence s_mode_stays;
    clkEn && !(regWrStrobe && (regAddr == cui_pkg::OFS_CLOCK_MODE_REG_SIX));
  endsequence

  a_lock_state_read: assert property (s_rd_pll |=> regRdData[1] == $past(st.pllLockState))
    else $error("Lock state bit wrong on read");

  a_chan_bit_seven: assert property (s_rd_chan |=>
    regRdData[7] == ($past(st.compatSel) ? $past(st.pllLockState) : $past(channelSummaryIn[7])))
    else $error("Channel summary bit seven wrong");

  a_lock_change_flag: assert property ((clkEn && pllLockSync != st.pllLockState) |=>
    st.pllChanged ##1 (st.pllChanged || $past(rdPll)))
    else $error("Lock change flag not held");

  a_switch_read_clear: assert property ((clkEn && rdSwitch && !dcoRefSwapEvt && !txSrcSwapEvt)
    |=> !st.dcoRefSwap && !st.txSrcSwap)
    else $error("Switch flags not cleared by read");

  a_masked_recorded: assert property ((s_mode_stays and (st.autoSwitchEn && st.showMasked
    && txSrcSwapEvt)) |=> st.txSrcSwap)
    else $error("Masked event not recorded");

  a_irq_from_flags: assert property (clkEn |=> irqOut == (st.pllChanged
    || (|switchPending)))
    else $error("Interrupt output disagrees with unmasked flags");

  a_dco_swap_flag: assert property ((clkEn && st.autoSwitchEn && dcoRefSwapEvt
    && !st.mask[4]) |=> st.dcoRefSwap)
    else $error("DCO reference switch not flagged");

  a_auto_off_zero: assert property ((s_mode_stays and !st.autoSwitchEn) |=>
    !st.dcoRefSwap && !st.txSrcSwap)
    else $error("Switch flag set with auto switching off");

  a_src_swap_flag: assert property ((clkEn && st.autoSwitchEn && txSrcSwapEvt
    && !st.mask[3]) |=> st.txSrcSwap)
    else $error("Transmit source switch not flagged");

  a_loss_visible: assert property (s_rd_loss |=>
    regRdData == {3'h0, $past(txRefLossSync), 4'h0})
    else $error("Reference loss bit wrong");

  a_reserved_zero: assert property (s_rd_pll |=> regRdData[7:2] == 6'h00)
    else $error("Reserved bits not zero");

  // ---------------------------------------------------------------------
  // Read path and summary checks
  // ---------------------------------------------------------------------

  // Summary reads; the summary never clears anything itself
  sequence s_rd_sum;
    clkEn && regRdStrobe && (regAddr == cui_pkg::OFS_GLOBAL_IRQ_SUMMARY);
  endsequence

  // The lock bit tracks the synchronised pin, read or not
  a_lock_follows_pin: assert property (clkEn |=>
    st.pllLockState == $past(pllLockSync))
    else $error("Lock state does not follow pin");

  // A read with no new change in its cycle leaves the flag clear
  a_lock_flag_clear: assert property ((s_rd_pll and (pllLockSync == st.pllLockState)) |=>
    !st.pllChanged)
    else $error("Lock change flag not cleared by read");

  a_sum_lock: assert property (s_rd_sum |=>
    regRdData[0] == $past(st.pllChanged))
    else $error("Summary lock bit wrong");

  // Masked flags kept by the show-masked option stay out of the summary
  a_sum_masked: assert property (s_rd_sum |=> regRdData[1] == $past(st.autoSwitchEn
    && ((st.dcoRefSwap && !st.mask[4]) || (st.txSrcSwap && !st.mask[3]))))
    else $error("Summary switch bit wrong");

  a_auto_off_read: assert property ((clkEn && rdSwitch && !st.autoSwitchEn) |=>
    regRdData == 8'h00)
    else $error("Switch flags read nonzero with auto switching off");

  a_chan_low_bits: assert property (s_rd_chan |=>
    regRdData[6:0] == $past(channelSummaryIn[6:0]))
    else $error("Channel summary low bits wrong");

  // Only the two switch flags may ever show in the switch status
  a_switch_reserved: assert property ((clkEn && rdSwitch) |=> (regRdData & 8'he7) == 8'h00)
    else $error("Reserved switch status bits not zero");

  a_mask_reserved: assert property ((clkEn && regWrStrobe) |=>
    (st.mask & ~cui_pkg::MASK_WRITABLE) == 8'h00)
    else $error("Reserved mask bits were written");

  // The lock status register ignores writes; only a read clears it
  a_status_no_write: assert property ((clkEn && regWrStrobe
    && (regAddr == cui_pkg::OFS_PLL_LOCK_STATUS)) |=>
    st.pllChanged == $past(st.pllChanged || (pllLockSync != st.pllLockState)))
    else $error("Write altered the lock change flag");

endmodule : cui_clock_unit_irq_status

// [logic/cui_pkg.sv]
// Constants and state types for the clock unit interrupt and status block.
// Assumes an 8-bit register port addressed by the printed byte offsets.
package cui_pkg;

  // ---------------------------------------------------------------------
  // Register port geometry
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_PLL_LOCK_STATUS = 8'had;
  localparam logic [7:0] OFS_CLOCK_SWITCH_IRQ_STATUS = 8'hd8;
  localparam logic [7:0] OFS_CHANNEL_IRQ_SUMMARY = 8'h6f;
  localparam logic [7:0] OFS_GLOBAL_CONFIG_REG = 8'hc0;
  localparam logic [7:0] OFS_CLOCK_MODE_REG_SIX = 8'hc1;
  localparam logic [7:0] OFS_CLOCK_SWITCH_MASK_REG = 8'hc2;
  localparam logic [7:0] OFS_CLOCK_LOSS_STATUS_REG = 8'hc3;
  localparam logic [7:0] OFS_GLOBAL_IRQ_SUMMARY = 8'hc4;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int POS_PLL_LOCK_CHANGED = 0;
  localparam int POS_PLL_LOCK_STATE = 1;
  localparam int POS_TXCLK_SRC_SWAP = 3;
  localparam int POS_DCO_REF_SWAP = 4;
  localparam int POS_CHANNEL8_SUMMARY = 7;
  localparam int POS_TX_REF_LOSS_STATE = 4;
  localparam int POS_SHOW_MASKED = 0;
  localparam int POS_COMPAT_SEL = 1;
  localparam int POS_AUTO_SWITCH_EN = 0;
  localparam int POS_SRC_SWITCH_SCHEME = 1;
  localparam int POS_SUM_PLL = 0;
  localparam int POS_SUM_CLOCK_SWITCH = 1;

  // Writable bits of the mask register; the rest are reserved
  localparam logic [7:0] MASK_WRITABLE = 8'h18;

  // ---------------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic RST_SHOW_MASKED = 1'b0;
  localparam logic RST_COMPAT_SEL = 1'b0;
  localparam logic RST_AUTO_SWITCH_EN = 1'b0;
  localparam logic RST_SRC_SWITCH_SCHEME = 1'b0;
  localparam logic [7:0] RST_RD_DATA = 8'h00;
  localparam int SYNC_W = 2;

  // ---------------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] q;
  } cui_sync_s;

  typedef struct packed {
    logic scheme;
    logic txClkSrcDco;
    logic dcoRefFixed;
    logic dcoRefSwapEvt;
    logic txSrcSwapEvt;
  } cui_switch_s;

  typedef struct packed {
    logic showMasked;
    logic compatSel;
    logic autoSwitchEn;
    logic srcSwitchScheme;
    logic [7:0] mask;
    logic pllLockState;
    logic pllChanged;
    logic dcoRefSwap;
    logic txSrcSwap;
    logic [7:0] rdData;
    logic irqOut;
  } cui_top_s;

endpackage : cui_pkg

// [logic/cui_switch.sv]
// Automatic transmit clock switching selector and switch event source.
// Assumes the loss level is already synchronised to ref_clk.
`timescale 1ns/1ns
module cui_switch (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic autoSwitchEn,
  input wire logic srcSwitchScheme,
  input wire logic txRefLoss,
  output logic txClkSrcDco,
  output logic dcoRefFixed,
  output logic dcoRefSwapEvt,
  output logic txSrcSwapEvt
);

  cui_pkg::cui_switch_s st;
  cui_pkg::cui_switch_s next_st;
  logic swapWanted;

  // ---------------------------------------------------------------------
  // Source selection per scheme; events only on switches within a scheme
  // ---------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    swapWanted = autoSwitchEn & txRefLoss;
    next_st.scheme = srcSwitchScheme;
    if (srcSwitchScheme)
    begin
      next_st.dcoRefFixed = 1'b1;
      next_st.txClkSrcDco = swapWanted;
    end
    else
    begin
      next_st.txClkSrcDco = 1'b1;
      next_st.dcoRefFixed = swapWanted;
    end
    // A scheme change is a reconfiguration, not an automatic switch
    next_st.txSrcSwapEvt = autoSwitchEn & srcSwitchScheme & (st.scheme == srcSwitchScheme)
      & (next_st.txClkSrcDco != st.txClkSrcDco);
    next_st.dcoRefSwapEvt = autoSwitchEn & ~srcSwitchScheme & (st.scheme == srcSwitchScheme)
      & (next_st.dcoRefFixed != st.dcoRefFixed);
  end

  // Registered state, frozen while the clock enable is low
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      st <= '0;
    else if (clkEn)
      st <= next_st;
  end

  assign txClkSrcDco = st.txClkSrcDco;
  assign dcoRefFixed = st.dcoRefFixed;
  assign dcoRefSwapEvt = st.dcoRefSwapEvt;
  assign txSrcSwapEvt = st.txSrcSwapEvt;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  a_dco_ref_fixed: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clkEn && srcSwitchScheme) |=> dcoRefFixed)
    else $error("DCO reference not fixed in source switch scheme");

  a_txclk_from_dco: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clkEn && !srcSwitchScheme) |=> txClkSrcDco)
    else $error("Transmit clock not from DCO in reference switch scheme");

endmodule : cui_switch

// [logic/cui_sync.sv]
// Three-stage input synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to ref_clk; output is a clean level.
`timescale 1ns/1ns
module cui_sync (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [cui_pkg::SYNC_W-1:0] pinIn,
  output logic [cui_pkg::SYNC_W-1:0] levelOut
);

  cui_pkg::cui_sync_s st;
  cui_pkg::cui_sync_s next_st;

  // ---------------------------------------------------------------------
  // Next state: a bit moves only once stages two and three agree
  // ---------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.s1 = pinIn;
    next_st.s2 = st.s1; // First stage feeds only the second
    next_st.s3 = st.s2;
    next_st.q = (~(st.s2 ^ st.s3) & st.s2) | ((st.s2 ^ st.s3) & st.q);
  end

  // Registered state, frozen while the clock enable is low
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      st <= '0;
    else if (clkEn)
      st <= next_st;
  end

  assign levelOut = st.q;

endmodule : cui_sync

// [verification/tb_clock_unit_irq_status.sv]
// Self-checking bench for the clock unit interrupt and status block.
// Assumes the bench drives every port of the block itself, on one clock.
`timescale 1ns/1ns
module tb_clock_unit_irq_status;

  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrStrobe = 1'b0;
  logic regRdStrobe = 1'b0;
  logic [7:0] regRdData;
  logic pllLockRaw = 1'b0;
  logic txRefLossRaw = 1'b0;
  logic [7:0] channelSummaryIn = 8'h00;
  logic irqOut;
  logic txClkSrcDco;
  logic dcoRefFixed;
  int nMismatch = 0;
  int nTests = 0;

  // Free-running 25 MHz clock
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end

  cui_clock_unit_irq_status i_dut (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe),
    .regRdData(regRdData),
    .pllLockRaw(pllLockRaw),
    .txRefLossRaw(txRefLossRaw),
    .channelSummaryIn(channelSummaryIn),
    .irqOut(irqOut),
    .txClkSrcDco(txClkSrcDco),
    .dcoRefFixed(dcoRefFixed)
  );

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic endSim();
    $display("Comparisons %0d, mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : endSim

  // Case inequality so an unknown never counts as a match
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    nTests++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWrStrobe <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrStrobe <= 1'b0;
  endtask : regWrite

  // Read data stands only in the cycle after the strobe, so sample it there
  task automatic readCheck(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    regRdStrobe <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRdStrobe <= 1'b0;
    #1;
    check(what, exp, regRdData);
  endtask : readCheck

  task automatic pin(input logic lock, input logic loss);
    @(posedge ref_clk);
    pllLockRaw <= lock;
    txRefLossRaw <= loss;
  endtask : pin

  // Covers synchroniser depth plus event and flag stages with margin
  task automatic settle();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic waitIrq(input logic exp);
    int k;
    k = 0;
    #1;
    while (irqOut !== exp && k < 12)
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (irqOut !== exp)
    begin
      nMismatch++;
      $display("[ERR] irqOut wait expected %h seen %h", exp, irqOut);
      endSim();
    end
  endtask : waitIrq

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic testReset();
    check("srcDco", 8'h01, {7'h00, txClkSrcDco});
    check("irqOut", 8'h00, {7'h00, irqOut});
    readCheck(8'had, 8'h00, "lockReg");
    readCheck(8'hd8, 8'h00, "swReg");
    readCheck(8'h01, 8'h00, "unmapped");
    regWrite(8'had, 8'hff);
    regWrite(8'hd8, 8'hff);
    readCheck(8'had, 8'h00, "lockReg");
    readCheck(8'hd8, 8'h00, "swReg");
    regWrite(8'hc2, 8'hff);
    readCheck(8'hc2, cui_pkg::MASK_WRITABLE, "maskReg");
    regWrite(8'hc2, 8'h00);
    $display("test reset done");
  endtask : testReset

  // A low clock enable freezes the read data that a read left behind
  task automatic testHold();
    regWrite(8'hc2, 8'hff);
    @(posedge ref_clk);
    regRdStrobe <= 1'b1;
    regAddr <= 8'hc2;
    @(posedge ref_clk);
    regRdStrobe <= 1'b0;
    clkEn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    check("heldRd", cui_pkg::MASK_WRITABLE, regRdData);
    @(posedge ref_clk);
    clkEn <= 1'b1;
    @(posedge ref_clk);
    #1;
    check("freedRd", 8'h00, regRdData);
    regWrite(8'hc2, 8'h00);
    $display("test hold done");
  endtask : testHold

  // Lock state is a plain bit; only the change flag clears on read
  task automatic testPll();
    pin(1'b1, 1'b0);
    waitIrq(1'b1);
    readCheck(8'hc4, 8'h01, "sumReg");
    readCheck(8'had, 8'h03, "lockReg");
    readCheck(8'had, 8'h02, "lockReg");
    waitIrq(1'b0);
    pin(1'b0, 1'b0);
    waitIrq(1'b1);
    readCheck(8'had, 8'h01, "lockReg");
    readCheck(8'had, 8'h00, "lockReg");
    waitIrq(1'b0);
    $display("test pll done");
  endtask : testPll

  // Top summary bit follows the lock only with compat select on
  task automatic testCompat();
    pin(1'b1, 1'b0);
    channelSummaryIn <= 8'h25;
    waitIrq(1'b1);
    readCheck(8'had, 8'h03, "lockReg");
    readCheck(8'h6f, 8'h25, "chanReg");
    regWrite(8'hc0, 8'h02);
    readCheck(8'h6f, 8'ha5, "chanReg");
    readCheck(8'had, 8'h02, "lockReg");
    pin(1'b0, 1'b0);
    channelSummaryIn <= 8'ha5;
    waitIrq(1'b1);
    readCheck(8'h6f, 8'h25, "chanReg");
    readCheck(8'had, 8'h01, "lockReg");
    regWrite(8'hc0, 8'h00);
    readCheck(8'h6f, 8'ha5, "chanReg");
    waitIrq(1'b0);
    $display("test compat done");
  endtask : testCompat

  task automatic testAutoOff();
    pin(1'b0, 1'b1);
    settle();
    readCheck(8'hc3, 8'h10, "lossReg");
    readCheck(8'hd8, 8'h00, "swReg");
    check("refFixed", 8'h00, {7'h00, dcoRefFixed});
    check("irqOut", 8'h00, {7'h00, irqOut});
    pin(1'b0, 1'b0);
    settle();
    readCheck(8'hc3, 8'h00, "lossReg");
    $display("test auto off done");
  endtask : testAutoOff

  // Reference scheme: DCO reference moves, tx clock stays on the DCO
  task automatic testRefSwap();
    regWrite(8'hc1, 8'h01);
    pin(1'b0, 1'b1);
    waitIrq(1'b1);
    check("refFixed", 8'h01, {7'h00, dcoRefFixed});
    check("srcDco", 8'h01, {7'h00, txClkSrcDco});
    readCheck(8'hc3, 8'h10, "lossReg");
    readCheck(8'hc4, 8'h02, "sumReg");
    readCheck(8'hd8, 8'h10, "swReg");
    readCheck(8'hd8, 8'h00, "swReg");
    waitIrq(1'b0);
    pin(1'b0, 1'b0);
    waitIrq(1'b1);
    check("refFixed", 8'h00, {7'h00, dcoRefFixed});
    check("srcDco", 8'h01, {7'h00, txClkSrcDco});
    regWrite(8'hc1, 8'h00);
    readCheck(8'hd8, 8'h00, "swReg");
    waitIrq(1'b0);
    $display("test ref swap done");
  endtask : testRefSwap

  // Source scheme: tx clock moves, DCO stays on the fixed reference
  task automatic testSrcSwap();
    regWrite(8'hc1, 8'h03);
    settle();
    check("refFixed", 8'h01, {7'h00, dcoRefFixed});
    check("srcDco", 8'h00, {7'h00, txClkSrcDco});
    readCheck(8'hd8, 8'h00, "swReg");
    pin(1'b0, 1'b1);
    waitIrq(1'b1);
    check("srcDco", 8'h01, {7'h00, txClkSrcDco});
    check("refFixed", 8'h01, {7'h00, dcoRefFixed});
    readCheck(8'hd8, 8'h08, "swReg");
    waitIrq(1'b0);
    pin(1'b0, 1'b0);
    waitIrq(1'b1);
    check("srcDco", 8'h00, {7'h00, txClkSrcDco});
    readCheck(8'hd8, 8'h08, "swReg");
    readCheck(8'hd8, 8'h00, "swReg");
    waitIrq(1'b0);
    $display("test src swap done");
  endtask : testSrcSwap

  // Masked events show only with show-masked on, and never reach the pin
  task automatic testMask();
    regWrite(8'hc2, 8'h08);
    pin(1'b0, 1'b1);
    settle();
    check("irqOut", 8'h00, {7'h00, irqOut});
    readCheck(8'hd8, 8'h00, "swReg");
    regWrite(8'hc0, 8'h01);
    pin(1'b0, 1'b0);
    settle();
    check("irqOut", 8'h00, {7'h00, irqOut});
    readCheck(8'hc4, 8'h00, "sumReg");
    readCheck(8'hd8, 8'h08, "swReg");
    regWrite(8'hc2, 8'h00);
    regWrite(8'hc0, 8'h00);
    regWrite(8'hc1, 8'h00);
    $display("test mask done");
  endtask : testMask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    testReset();
    testHold();
    testPll();
    testCompat();
    testAutoOff();
    testRefSwap();
    testSrcSwap();
    testMask();
    endSim();
  end

endmodule : tb_clock_unit_irq_status
